// File: common/timer16_pkg.sv
// Behaviour
// - counter, compares and capture are 16-bit, reached as two byte accesses
// - one shared high-byte holding latch serves every 16-bit register
// - low-byte write loads latch byte and new low byte in one cycle; capture takes it only while capture is top
// - counter or capture low-byte read copies the register's upper byte into the latch
// - compare reads return both bytes directly, latch untouched
// - both control registers are plain 8-bit read/write registers
// - four event flags in one flag register, each gated by a mask bit
// - clock from prescaler or event pin; no source keeps counter still
// - compare values checked against counter on each count tick; equality sets match flag
// - selected capture edge copies counter into capture unless capture is top, optional noise filter
// - top is 0xFFFF, 0x00FF, 0x01FF, 0x03FF, compare A or capture by mode
// - compare A as PWM top gives no A waveform, top double-buffered
// - bottom signalled at 0x0000, max at 0xFFFF
// - two compare channels, each driving four pins U, V, W, X
// - counter high-byte location reaches the latch, not the counter
// - software counter write beats clear and count in the same cycle
// - clock select zero stops timer; counter stays readable and writable
// - capture flag set with the capture; cleared by acknowledge or write-one
package timer16_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int CNT_W  = 16;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [3:0] OFS_CTRL_A   = 4'h0;
   localparam logic [3:0] OFS_CTRL_B   = 4'h1;
   localparam logic [3:0] OFS_FLAG     = 4'h2;
   localparam logic [3:0] OFS_MASK     = 4'h3;
   localparam logic [3:0] OFS_COUNT_L  = 4'h4;
   localparam logic [3:0] OFS_COUNT_H  = 4'h5;
   localparam logic [3:0] OFS_CAPT_L   = 4'h6;
   localparam logic [3:0] OFS_CAPT_H   = 4'h7;
   localparam logic [3:0] OFS_CMPA_L   = 4'h8;
   localparam logic [3:0] OFS_CMPA_H   = 4'h9;
   localparam logic [3:0] OFS_CMPB_L   = 4'hA;
   localparam logic [3:0] OFS_CMPB_H   = 4'hB;
   localparam logic [3:0] OFS_PIN_EN   = 4'hC;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CTRL_A_MODE_LSB = 0;   // mode in [2:0]
   localparam int CTRL_B_CS_LSB   = 0;   // clock select in [2:0]
   localparam int CTRL_B_EDGE     = 3;   // capture on rising edge when set
   localparam int CTRL_B_FILT     = 4;   // noise filter enable
   localparam int CTRL_B_SRC      = 5;   // capture from comparator when set
   localparam int FLAG_OVF        = 0;
   localparam int FLAG_MATCH_A    = 1;
   localparam int FLAG_MATCH_B    = 2;
   localparam int FLAG_CAPT       = 3;

   // ****************************************
   // reset values and fixed values
   // ****************************************
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [15:0] CNT_RST    = 16'h0000;
   localparam logic [15:0] BOTTOM_VAL = 16'h0000;
   localparam logic [15:0] MAX_VAL    = 16'hFFFF;
   localparam logic [15:0] TOP_8BIT   = 16'h00FF;
   localparam logic [15:0] TOP_9BIT   = 16'h01FF;
   localparam logic [15:0] TOP_10BIT  = 16'h03FF;
   localparam int          FILT_LEN   = 4;

   // ****************************************
   // modes and clock selects
   // ****************************************
   typedef enum logic [2:0] {
      MODE_NORMAL  = 3'h0,
      MODE_FIX8    = 3'h1,
      MODE_FIX9    = 3'h2,
      MODE_FIX10   = 3'h3,
      MODE_CTC_A   = 3'h4,
      MODE_CTC_CAP = 3'h5,
      MODE_PWM_A   = 3'h6,
      MODE_PWM_CAP = 3'h7
   } mode_t;

   typedef enum logic [2:0] {
      CS_STOP    = 3'h0,
      CS_DIV1    = 3'h1,
      CS_DIV8    = 3'h2,
      CS_DIV64   = 3'h3,
      CS_DIV256  = 3'h4,
      CS_DIV1024 = 3'h5,
      CS_EXT_FAL = 3'h6,
      CS_EXT_RIS = 3'h7
   } clk_sel_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } bus_req_t;

   typedef struct packed {
      logic [3:0] pins_a;   // U, V, W, X order from bit 0
      logic [3:0] pins_b;
   } cmp_pins_t;

endpackage

// File: design/edge_filter_detect.sv
`timescale 1ns/1ns
`default_nettype none
module edge_filter_detect
   import timer16_pkg::*;
#(
   parameter int LEN = FILT_LEN
)(
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_sys_rst,
   // control
   input  wire logic i_filt_en,
   input  wire logic i_rising,
   // signal
   input  wire logic i_level,
   output logic      o_edge
);
   logic [LEN-1:0] hist_r;
   logic           filt_r;
   logic           prev_r;
   logic           cur;

   // ****************************************
   // noise filter: output moves only when all samples agree
   // ****************************************
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         hist_r <= '0;
         filt_r <= 1'b0;
      end else begin
         hist_r <= {hist_r[LEN-2:0], i_level};
         if (&hist_r)
            filt_r <= 1'b1;
         else if (~|hist_r)
            filt_r <= 1'b0;
      end
   end

   assign cur = i_filt_en ? filt_r : i_level;

   // ****************************************
   // edge detector
   // ****************************************
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         prev_r <= 1'b0;
         o_edge <= 1'b0;
      end else begin
         prev_r <= cur;
         o_edge <= i_rising ? (cur & ~prev_r) : (~cur & prev_r);
      end
   end
endmodule
`default_nettype wire

// File: design/timer16_core.sv
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module timer16_core
   import timer16_pkg::*;
#(
   parameter int PRESC_W = 10
)(
   // clock and reset
   input  wire logic      i_core_clk,
   input  wire logic      i_sys_rst,
   // register port
   input  wire bus_req_t  i_bus,
   output logic [7:0]     o_rdata,
   // external events
   input  wire logic      i_event_clock_pin,
   input  wire logic      i_capture_pin,
   input  wire logic      i_comparator_output,
   input  wire logic [3:0] i_irq_ack,
   // status
   output logic [3:0]     o_irq_req,
   output logic           o_at_bottom,
   output logic           o_at_max,
   output cmp_pins_t      o_pins
);
   import timer16_pkg::*;

   // ****************************************
   // state
   // ****************************************
   logic [7:0]         ctrl_a_r;
   logic [7:0]         ctrl_b_r;
   logic [7:0]         pin_en_r;
   logic [3:0]         flag_r;
   logic [3:0]         mask_r;
   logic [7:0]         temp_r;
   logic [15:0]        count_r;
   logic [15:0]        capt_r;
   logic [15:0]        cmpa_buf_r;
   logic [15:0]        cmpb_buf_r;
   logic [15:0]        cmpa_r;
   logic [15:0]        cmpb_r;
   logic [PRESC_W-1:0] presc_r;
   logic               wave_a_r;
   logic               wave_b_r;

   mode_t       mode;
   clk_sel_t    cs;
   logic        tick;
   logic        ext_edge;
   logic        capt_edge;
   logic        capt_level;
   logic [15:0] top;
   logic        at_top;
   logic        wrap;
   logic        cnt_wr;
   logic [15:0] count_nxt;
   logic        match_a;
   logic        match_b;
   logic        capt_ev;
   logic        capt_is_top;
   logic [3:0]  flag_set;
   logic [3:0]  flag_clr;
   logic        wr;
   logic        rd;
   logic [3:0]  addr;

   function automatic logic is_pwm(input mode_t m);
      return (m == MODE_PWM_A) || (m == MODE_PWM_CAP) ||
             (m == MODE_FIX8) || (m == MODE_FIX9) || (m == MODE_FIX10);
   endfunction

   assign wr   = i_bus.wr;
   assign rd   = i_bus.rd;
   assign addr = i_bus.addr;
   assign mode = mode_t'(ctrl_a_r[CTRL_A_MODE_LSB +: 3]);
   assign cs   = clk_sel_t'(ctrl_b_r[CTRL_B_CS_LSB +: 3]);

   // ****************************************
   // clock select and prescaler
   // ****************************************
   // prescaler runs free, independent of the clock select
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst)
         presc_r <= '0;
      else
         presc_r <= presc_r + 1'b1;
   end

   edge_filter_detect #(.LEN(FILT_LEN)) u_event_edge (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_filt_en  (1'b0),
      .i_rising   (cs == CS_EXT_RIS),
      .i_level    (i_event_clock_pin),
      .o_edge     (ext_edge)
   );

   always_comb begin
      case (cs)
         CS_STOP:    tick = 1'b0;
         CS_DIV1:    tick = 1'b1;
         CS_DIV8:    tick = &presc_r[2:0];
         CS_DIV64:   tick = &presc_r[5:0];
         CS_DIV256:  tick = &presc_r[7:0];
         CS_DIV1024: tick = &presc_r[9:0];
         CS_EXT_FAL: tick = ext_edge;
         CS_EXT_RIS: tick = ext_edge;
         default:    tick = 1'b0;
      endcase
   end

   // ****************************************
   // top select and counter
   // ****************************************
   always_comb begin
      case (mode)
         MODE_FIX8:    top = TOP_8BIT;
         MODE_FIX9:    top = TOP_9BIT;
         MODE_FIX10:   top = TOP_10BIT;
         MODE_CTC_A:   top = cmpa_r;
         MODE_PWM_A:   top = cmpa_r;
         MODE_CTC_CAP: top = capt_r;
         MODE_PWM_CAP: top = capt_r;
         default:      top = MAX_VAL;
      endcase
   end

   assign at_top = (count_r == top);
   assign wrap   = tick & at_top;
   assign cnt_wr = wr & (addr == OFS_COUNT_L);

   always_comb begin
      if (cnt_wr)
         count_nxt = {temp_r, i_bus.wdata};
      else if (wrap)
         count_nxt = BOTTOM_VAL;
      else if (tick)
         count_nxt = count_r + 16'h0001;
      else
         count_nxt = count_r;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         count_r     <= CNT_RST;
         o_at_bottom <= 1'b1;
         o_at_max    <= 1'b0;
      end else begin
         count_r     <= count_nxt;
         o_at_bottom <= (count_nxt == BOTTOM_VAL);
         o_at_max    <= (count_nxt == MAX_VAL);
      end
   end

   // ****************************************
   // compare channels
   // ****************************************
   // buffered values move to the active ones at top in pwm modes, so a
   // period never sees a half-updated threshold
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         cmpa_buf_r <= CNT_RST;
         cmpb_buf_r <= CNT_RST;
         cmpa_r     <= CNT_RST;
         cmpb_r     <= CNT_RST;
      end else begin
         if (wr && addr == OFS_CMPA_L)
            cmpa_buf_r <= {temp_r, i_bus.wdata};
         if (wr && addr == OFS_CMPB_L)
            cmpb_buf_r <= {temp_r, i_bus.wdata};
         if (!is_pwm(mode) || wrap) begin
            cmpa_r <= cmpa_buf_r;
            cmpb_r <= cmpb_buf_r;
         end
      end
   end

   assign match_a = tick & (count_r == cmpa_r);
   assign match_b = tick & (count_r == cmpb_r);

   // ****************************************
   // waveforms and pins
   // ****************************************
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         wave_a_r <= 1'b0;
         wave_b_r <= 1'b0;
         o_pins   <= '0;
      end else begin
         if (mode == MODE_PWM_A)
            wave_a_r <= 1'b0;
         else if (is_pwm(mode))
            wave_a_r <= (count_nxt < cmpa_r);
         else if (match_a)
            wave_a_r <= ~wave_a_r;
         if (is_pwm(mode))
            wave_b_r <= (count_nxt < cmpb_r);
         else if (match_b)
            wave_b_r <= ~wave_b_r;
         o_pins.pins_a <= pin_en_r[3:0] & {4{wave_a_r}};
         o_pins.pins_b <= pin_en_r[7:4] & {4{wave_b_r}};
      end
   end

   // ****************************************
   // input capture
   // ****************************************
   assign capt_level  = ctrl_b_r[CTRL_B_SRC] ? i_comparator_output
                                              : i_capture_pin;
   assign capt_is_top = (mode == MODE_CTC_CAP) || (mode == MODE_PWM_CAP);

   edge_filter_detect #(.LEN(FILT_LEN)) u_capt_edge (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_filt_en  (ctrl_b_r[CTRL_B_FILT]),
      .i_rising   (ctrl_b_r[CTRL_B_EDGE]),
      .i_level    (capt_level),
      .o_edge     (capt_edge)
   );

   // capture is off while the capture register holds top
   assign capt_ev = capt_edge & ~capt_is_top;

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst)
         capt_r <= CNT_RST;
      else if (capt_is_top && wr && addr == OFS_CAPT_L)
         capt_r <= {temp_r, i_bus.wdata};
      else if (capt_ev)
         capt_r <= count_r;
   end

   // ****************************************
   // shared high-byte latch
   // ****************************************
   // one latch for all 16-bit registers; an interrupting access in the
   // middle of a byte pair corrupts it, so software must guard pairs
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst)
         temp_r <= 8'h00;
      else if (wr && (addr == OFS_COUNT_H || addr == OFS_CAPT_H ||
                      addr == OFS_CMPA_H || addr == OFS_CMPB_H))
         temp_r <= i_bus.wdata;
      else if (rd && addr == OFS_COUNT_L)
         temp_r <= count_r[15:8];
      else if (rd && addr == OFS_CAPT_L)
         temp_r <= capt_r[15:8];
   end

   // ****************************************
   // control, mask and flags
   // ****************************************
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         ctrl_a_r <= CTRL_RST;
         ctrl_b_r <= CTRL_RST;
         mask_r   <= 4'h0;
         pin_en_r <= CTRL_RST;
      end else if (wr) begin
         if (addr == OFS_CTRL_A)
            ctrl_a_r <= i_bus.wdata;
         if (addr == OFS_CTRL_B)
            ctrl_b_r <= i_bus.wdata;
         if (addr == OFS_MASK)
            mask_r <= i_bus.wdata[3:0];
         if (addr == OFS_PIN_EN)
            pin_en_r <= i_bus.wdata;
      end
   end

   always_comb begin
      flag_set               = 4'h0;
      flag_set[FLAG_OVF]     = wrap;
      flag_set[FLAG_MATCH_A] = match_a;
      flag_set[FLAG_MATCH_B] = match_b;
      flag_set[FLAG_CAPT]    = capt_ev;
      flag_clr = i_irq_ack;
      if (wr && addr == OFS_FLAG)
         flag_clr = flag_clr | i_bus.wdata[3:0];
   end

   // a set in the same cycle as a clear wins
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         flag_r    <= 4'h0;
         o_irq_req <= 4'h0;
      end else begin
         flag_r    <= (flag_r & ~flag_clr) | flag_set;
         o_irq_req <= ((flag_r & ~flag_clr) | flag_set) & mask_r;
      end
   end

   // ****************************************
   // read port
   // ****************************************
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            OFS_CTRL_A:  o_rdata <= ctrl_a_r;
            OFS_CTRL_B:  o_rdata <= ctrl_b_r;
            OFS_FLAG:    o_rdata <= {4'h0, flag_r};
            OFS_MASK:    o_rdata <= {4'h0, mask_r};
            OFS_COUNT_L: o_rdata <= count_r[7:0];
            OFS_COUNT_H: o_rdata <= temp_r;
            OFS_CAPT_L:  o_rdata <= capt_r[7:0];
            OFS_CAPT_H:  o_rdata <= temp_r;
            OFS_CMPA_L:  o_rdata <= cmpa_buf_r[7:0];
            OFS_CMPA_H:  o_rdata <= cmpa_buf_r[15:8];
            OFS_CMPB_L:  o_rdata <= cmpb_buf_r[7:0];
            OFS_CMPB_H:  o_rdata <= cmpb_buf_r[15:8];
            OFS_PIN_EN:  o_rdata <= pin_en_r;
            default:     o_rdata <= 8'h00;
         endcase
      end else begin
         o_rdata <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// File: testbench/cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module cpu_model
   import timer16_pkg::*;
(
   // clock
   input  wire logic i_core_clk,
   // register port
   output var bus_req_t o_bus
);
   initial o_bus = '0;

   // caller sits just after an edge; the request stands until the next one
   task automatic access(input logic [3:0] a, input logic [7:0] d,
                         input logic w);
      @(posedge i_core_clk);
      o_bus <= '{addr: a, wdata: d, wr: w, rd: ~w};
   endtask

   // a released bus shows no stale address or data
   task automatic release_bus();
      @(posedge i_core_clk);
      o_bus <= '{addr: ~o_bus.addr, wdata: ~o_bus.wdata, wr: 1'b0, rd: 1'b0};
   endtask

   // high byte first, no gap, nothing else in between
   task automatic write16(input logic [3:0] lo, input logic [15:0] v);
      access(lo + 4'h1, v[15:8], 1'b1);
      access(lo, v[7:0], 1'b1);
      release_bus();
   endtask

   task automatic read16(input logic [3:0] lo);
      access(lo, 8'h00, 1'b0);
      access(lo + 4'h1, 8'h00, 1'b0);
      release_bus();
   endtask
endmodule
`default_nettype wire

// File: testbench/sixteen_bit_timer_core_access_bench.sv
`timescale 1ns/1ns
`default_nettype none
module sixteen_bit_timer_core_access_bench import timer16_pkg::*;;
   logic        core_clk;
   logic        sys_rst;
   logic        ev_pin;
   logic        cap_pin;
   logic        cmp_out;
   logic        at_bottom;
   logic        at_max;
   logic        rd_d = 1'b0;
   logic [3:0]  irq_ack;
   logic [3:0]  irq_req;
   logic [7:0]  rdata;
   logic [15:0] v;
   bus_req_t    bus;
   cmp_pins_t   pins;
   logic [7:0]  exp_q[$];
   int          n_errors = 0;
   int          checks = 0;
   logic [15:0] tops [8] = '{MAX_VAL, TOP_8BIT, TOP_9BIT, TOP_10BIT,
                             16'h0200, 16'h0200, 16'h0200, 16'h0200};

   cpu_model cpu_model_i (.i_core_clk(core_clk), .o_bus(bus));

   timer16_core timer16_core_i (
      .i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_bus(bus),
      .o_rdata(rdata), .i_event_clock_pin(ev_pin), .i_capture_pin(cap_pin),
      .i_comparator_output(cmp_out), .i_irq_ack(irq_ack),
      .o_irq_req(irq_req), .o_at_bottom(at_bottom), .o_at_max(at_max),
      .o_pins(pins));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ***************************************
   // result checking
   // ***************************************
   task automatic check8(input logic [7:0] e, input logic [7:0] got);
      checks++;
      if (got !== e) begin
         n_errors++;
         $display("Error at %0t: got %h, expected %h", $time, got, e);
      end
   endtask

   always @(posedge core_clk) begin
      if (rd_d)
         check8((exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX, rdata);
      rd_d <= bus.rd;
   end

   task automatic tally_and_finish();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ***************************************
   // bus helpers
   // ***************************************
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      cpu_model_i.access(a, 8'h00, 1'b0);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      cpu_model_i.access(a, d, 1'b1);
   endtask

   task automatic r16(input logic [3:0] a, input logic [15:0] e);
      exp_q.push_back(e[7:0]);
      exp_q.push_back(e[15:8]);
      cpu_model_i.read16(a);
   endtask

   task automatic idle(input int n);
      cpu_model_i.release_bus();
      repeat (n) @(posedge core_clk);
   endtask

   task automatic set_sel(input int k, input logic lvl);
      if (k[2])
         cmp_out <= lvl;
      else
         cap_pin <= lvl;
   endtask

   // ***************************************
   // scenarios
   // ***************************************
   initial begin
      sys_rst = 1'b1;
      ev_pin = 1'b0;
      cap_pin = 1'b0;
      cmp_out = 1'b0;
      irq_ack = 4'h0;
      v = 16'($urandom(62));
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 16; a++)
         rd(4'(a), 8'h00);
      v = 16'($urandom);
      wr(OFS_CTRL_A, v[7:0]);
      wr(OFS_CTRL_B, {v[15:11], 3'h0});
      rd(OFS_CTRL_A, v[7:0]);
      rd(OFS_CTRL_B, {v[15:11], 3'h0});
      wr(OFS_CTRL_A, 8'h00);
      wr(OFS_CTRL_B, 8'h00);
      wr(OFS_MASK, 8'h0F);
      cpu_model_i.write16(OFS_COUNT_L, v);
      r16(OFS_COUNT_L, v);
      wr(OFS_COUNT_H, ~v[15:8]);
      r16(OFS_COUNT_L, v);
      rd(OFS_COUNT_L, v[7:0]);
      rd(OFS_COUNT_L, v[7:0]);
      wr(OFS_COUNT_H, v[7:0]);
      rd(OFS_CAPT_H, v[7:0]);
      wr(OFS_CMPA_L, v[15:8]);
      wr(OFS_COUNT_H, 8'h5A);
      rd(OFS_CMPA_L, v[15:8]);
      rd(OFS_COUNT_H, 8'h5A);
      rd(OFS_CMPA_H, v[7:0]);
      cpu_model_i.write16(OFS_CMPB_L, 16'h0010);
      cpu_model_i.write16(OFS_CMPA_L, 16'h0200);
      wr(OFS_CTRL_A, 8'h05);
      cpu_model_i.write16(OFS_CAPT_L, 16'h0200);
      r16(OFS_CAPT_L, 16'h0200);
      wr(OFS_FLAG, 8'h0F);
      // each mode runs through its top; compare A sits on the 0x0200 tops
      for (int m = 0; m < 8; m++) begin
         wr(OFS_CTRL_A, 8'(m));
         cpu_model_i.write16(OFS_COUNT_L, tops[m] - 16'h0002);
         wr(OFS_CTRL_B, 8'h01);
         idle(6);
         wr(OFS_CTRL_B, 8'h00);
         idle(3);
         v[7:0] = (tops[m] == 16'h0200) ? 8'h03 : 8'h01;
         @(negedge core_clk);
         check8(v[7:0], {4'h0, irq_req});
         rd(OFS_FLAG, v[7:0]);
         wr(OFS_FLAG, 8'h0F);
         rd(OFS_FLAG, 8'h00);
      end
      wr(OFS_CTRL_A, 8'h00);
      // a counter write while counting must win over the tick
      wr(OFS_CTRL_B, 8'h01);
      wr(OFS_COUNT_H, 8'h12);
      wr(OFS_COUNT_L, 8'h34);
      rd(OFS_COUNT_L, 8'h34);
      rd(OFS_COUNT_H, 8'h12);
      wr(OFS_CTRL_B, 8'h00);
      for (int cs = 6; cs < 8; cs++) begin
         cpu_model_i.write16(OFS_COUNT_L, 16'h0000);
         wr(OFS_CTRL_B, 8'(cs));
         idle(3);
         repeat (5) begin
            ev_pin <= 1'b1;
            repeat (3) @(posedge core_clk);
            ev_pin <= 1'b0;
            repeat (3) @(posedge core_clk);
         end
         wr(OFS_CTRL_B, 8'h00);
         r16(OFS_COUNT_L, 16'h0005);
      end
      // stopped at count 5: both pwm levels are high below 0x0010 in MODE_FIX8; MODE_PWM_A holds A low
      v = 16'($urandom);
      wr(OFS_PIN_EN, v[7:0]);
      wr(OFS_CTRL_A, 8'h01);
      idle(2);
      @(negedge core_clk);
      check8({v[3:0], v[7:4]}, pins);
      wr(OFS_CTRL_A, 8'h06);
      idle(2);
      @(negedge core_clk);
      check8({4'h0, v[7:4]}, pins);
      wr(OFS_CTRL_A, 8'h00);
      // k: bit0 rising edge, bit1 filter, bit2 comparator source
      for (int k = 0; k < 8; k++) begin
         cap_pin <= ~k[0];
         cmp_out <= ~k[0];
         wr(OFS_CTRL_B, {2'b00, k[2], k[1], k[0], 3'b000});
         v = 16'($urandom);
         cpu_model_i.write16(OFS_COUNT_L, v);
         idle(10);
         wr(OFS_FLAG, 8'h0F);
         idle(2);
         set_sel(k ^ 4, k[0]);
         if (k[1]) begin
            set_sel(k, k[0]);
            repeat (2) @(posedge core_clk);
            set_sel(k, ~k[0]);
         end
         idle(12);
         rd(OFS_FLAG, 8'h00);
         idle(0);
         set_sel(k, k[0]);
         idle(12);
         rd(OFS_FLAG, 8'h08);
         r16(OFS_CAPT_L, v);
         if (k[0]) begin
            irq_ack <= 4'h8;
            @(posedge core_clk);
            irq_ack <= 4'h0;
         end else
            wr(OFS_FLAG, 8'h08);
         rd(OFS_FLAG, 8'h00);
      end
      idle(4);
      tally_and_finish();
   end

   // the whole run needs under a thousand cycles
   initial begin
      repeat (30000) @(posedge core_clk);
      n_errors++;
      tally_and_finish();
   end
endmodule

bind timer16_core timer16_core_asserts timer16_core_asserts_i (
   .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus),
   .o_rdata(o_rdata), .o_irq_req(o_irq_req), .o_at_bottom(o_at_bottom),
   .o_at_max(o_at_max));
`default_nettype wire

// File: testbench/timer16_core_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module timer16_core_asserts
   import timer16_pkg::*;
(
   // clock and reset
   input wire logic       i_core_clk,
   input wire logic       i_sys_rst,
   // watched ports
   input wire bus_req_t   i_bus,
   input wire logic [7:0] o_rdata,
   input wire logic [3:0] o_irq_req,
   input wire logic       o_at_bottom,
   input wire logic       o_at_max
);
   logic [7:0] ctl_a_r;
   logic [7:0] ctl_b_r;
   logic [7:0] ctl_b_d_r;
   logic [3:0] mask_r;
   logic [3:0] mask_d_r;

   // shadow of the control bytes, so each check knows the mode it runs in
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         ctl_a_r <= 8'h00;
         ctl_b_r <= 8'h00;
         mask_r  <= 4'h0;
      end else if (i_bus.wr) begin
         case (i_bus.addr)
            OFS_CTRL_A: ctl_a_r <= i_bus.wdata;
            OFS_CTRL_B: ctl_b_r <= i_bus.wdata;
            OFS_MASK:   mask_r  <= i_bus.wdata[3:0];
            default:    ;
         endcase
      end
   end

   // one cycle old copies: requests are registered, so they lag the mask
   always_ff @(posedge i_core_clk) begin
      ctl_b_d_r <= ctl_b_r;
      mask_d_r  <= mask_r;
   end

   default clocking dc @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   rdata_idle_a: assert property (!i_bus.rd |=> o_rdata == 8'h00)
      else $error("read data outside read slot");
   bottom_read_a: assert property (i_bus.rd && i_bus.addr == OFS_COUNT_L
      && o_at_bottom |=> o_rdata == 8'h00)
      else $error("bottom flag disagrees with count");
   max_read_a: assert property (i_bus.rd && i_bus.addr == OFS_COUNT_L
      && o_at_max |=> o_rdata == 8'hFF)
      else $error("max flag disagrees with count");
   cnt_write_a: assert property ((i_bus.wr && i_bus.addr == OFS_COUNT_L)
      ##1 (i_bus.rd && i_bus.addr == OFS_COUNT_L)
      |=> o_rdata == $past(i_bus.wdata, 2))
      else $error("count write lost");
   shared_latch_a: assert property ((i_bus.wr && i_bus.addr == OFS_COUNT_H)
      ##1 (i_bus.rd && i_bus.addr == OFS_CAPT_H)
      |=> o_rdata == $past(i_bus.wdata, 2))
      else $error("holding byte not shared");
   cmp_direct_a: assert property ((i_bus.wr && i_bus.addr == OFS_COUNT_H)
      ##1 (i_bus.rd && i_bus.addr == OFS_CMPA_L)
      ##1 (i_bus.rd && i_bus.addr == OFS_COUNT_H)
      |=> o_rdata == $past(i_bus.wdata, 3))
      else $error("compare read disturbed holding byte");
   stop_hold_a: assert property ((i_bus.rd && i_bus.addr == OFS_COUNT_L
      && ctl_b_r[2:0] == 3'h0 && ctl_b_d_r[2:0] == 3'h0)
      ##1 (i_bus.rd && i_bus.addr == OFS_COUNT_L)
      |=> o_rdata == $past(o_rdata))
      else $error("stopped counter moved");
   irq_mask_a: assert property ((o_irq_req & ~(mask_r | mask_d_r)) == 4'h0)
      else $error("masked event requested");
   wrap_bottom_a: assert property (o_at_max && !i_bus.wr
      && ctl_a_r[2:0] == 3'h0 && ctl_b_r[2:0] == 3'h1
      && ctl_b_d_r[2:0] == 3'h1 |=> o_at_bottom)
      else $error("no wrap to bottom after max");
endmodule
`default_nettype wire
